/* File: logic/crp_pkg.sv */
// Constants and types shared by both ends of the control register port
// Function
// RQ1 - Two independent ports, each multi-master safe
// RQ2 - Slave address programmable, default 0xB2
// RQ3 - Device is only ever a slave
// RQ4 - Registers reached only through this port
// RQ5 - Address splits into space and offset
// RQ6 - Start, address, three address, three data, stop
// RQ7 - Master write byte order is fixed
// RQ8 - Direction bit selects write or read
// RQ9 - Read starts with address-only write phase
// RQ10 - Repeated start, then three bytes MSB first
// RQ11 - Master acks two bytes, nacks third, stops
// RQ12 - Device acks each written byte low
// RQ13 - One 24-bit write; read fetched before shifting
package crp_pkg;
   localparam int         CRP_CLK_HZ   = 25_000_000;
   localparam int         CRP_SCL_HZ   = 100_000;
   localparam int         CRP_QTR_CYC  = CRP_CLK_HZ / (4 * CRP_SCL_HZ);
   localparam logic [6:0] CRP_QTR_LAST = 7'(CRP_QTR_CYC - 1);
   localparam logic [7:0] CRP_DEF_ADDR = 8'hb2;
   localparam logic [3:0] CRP_ACK_BIT  = 4'h8;
   localparam logic [2:0] CRP_IDX_SPC  = 3'h1;
   localparam logic [2:0] CRP_IDX_OHI  = 3'h2;
   localparam logic [2:0] CRP_IDX_OLO  = 3'h3;
   localparam logic [2:0] CRP_IDX_DHI  = 3'h4;
   localparam logic [2:0] CRP_IDX_DMI  = 3'h5;
   localparam logic [2:0] CRP_IDX_DLO  = 3'h6;
   localparam logic [2:0] CRP_IDX_RLST = 3'h7;
   localparam logic [2:0] CRP_TX_LAST  = 3'h2;

   typedef enum logic [2:0] {
      DS_IDLE, DS_RX, DS_RX_ACK, DS_TX, DS_TX_ACK, DS_SKIP
   } crp_dev_st_t;

   typedef enum logic [1:0] {
      HS_IDLE, HS_START, HS_BIT, HS_STOP
   } crp_host_st_t;

   // Byte n of a 24-bit word, most significant first
   function automatic logic [7:0] crp_word_byte(input logic [23:0] w,
                                                input logic [1:0]  n);
      case (n)
         2'h0:    crp_word_byte = w[23:16];
         2'h1:    crp_word_byte = w[15:8];
         default: crp_word_byte = w[7:0];
      endcase
   endfunction : crp_word_byte
endpackage : crp_pkg

/* File: logic/crp_if.sv */
// Open-drain two-wire bus joining the host end and the device end
`timescale 1ns/1ps
interface crp_if;
   logic scl;
   logic sda;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;

   // Wired-AND: a line is low while any enabled driver pulls it low
   assign scl = ~(m_scl_oe & ~m_scl_o);
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
   modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                 output m_sda_o, output m_sda_oe);
endinterface : crp_if

/* File: logic/crp_device.sv */
// Device end: two-wire slave giving access to 24-bit control registers
`timescale 1ns/1ps
module crp_device
   import crp_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   crp_if.dev               bus,
   input  wire logic        addr_load_in,
   input  wire logic [7:0]  addr_val_in,
   input  wire logic [23:0] rdata_in,
   output logic             wr_out,
   output logic             rd_out,
   output logic [7:0]       space_out,
   output logic [15:0]      offset_out,
   output logic [23:0]      wdata_out,
   output logic [7:0]       own_addr_out,
   output logic             active_out
);

   ////////////////////////////////////////////////////////////////////
   crp_dev_st_t state;
   logic        scl_q;
   logic        sda_q;
   logic [3:0]  bit_cnt;
   logic [7:0]  shreg;
   logic [2:0]  byte_idx;
   logic        rd_mode;
   logic        ack_ok;
   logic [23:0] txbuf;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic        rx_done;
   logic        rx_accept;
   logic [7:0]  next_tx_byte;

   // Inputs are synchronous; one stage of history finds the edges
   assign scl_rise  = bus.scl & ~scl_q;
   assign scl_fall  = ~bus.scl & scl_q;
   assign start_det = scl_q & bus.scl & sda_q & ~bus.sda;
   assign stop_det  = scl_q & bus.scl & ~sda_q & bus.sda;
   assign rx_done   = (state == DS_RX) & scl_fall & (bit_cnt == CRP_ACK_BIT);
   assign next_tx_byte = crp_word_byte(txbuf, 2'(byte_idx + 3'h1));

   // Address byte matches own address; data bytes only while writing
   always_comb begin
      if (byte_idx == 3'h0) begin
         rx_accept = (shreg[7:1] == own_addr_out[7:1]);  // see RQ2
      end else begin
         rx_accept = ~rd_mode & (byte_idx <= CRP_IDX_DLO);  // see RQ6
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         scl_q       <= 1'b1;
         sda_q       <= 1'b1;
         bus.s_sda_o <= 1'b0;
      end else begin
         scl_q       <= bus.scl;
         sda_q       <= bus.sda;
         bus.s_sda_o <= 1'b0;
      end
   end

   // Firmware may move the slave address at any time
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         own_addr_out <= CRP_DEF_ADDR;  // see RQ2
      end else if (addr_load_in) begin
         own_addr_out <= addr_val_in;  // see RQ2
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Only SDA is ever driven: no SCL driver, no request of our own
   always_ff @(posedge clk_in) begin  // see RQ3
      if (!resetn_in) begin
         state        <= DS_IDLE;
         bit_cnt      <= 4'h0;
         shreg        <= 8'h00;
         byte_idx     <= 3'h0;
         rd_mode      <= 1'b0;
         ack_ok       <= 1'b0;
         txbuf        <= 24'h000000;
         bus.s_sda_oe <= 1'b0;
      end else if (stop_det) begin
         state        <= DS_IDLE;  // see RQ6
         bus.s_sda_oe <= 1'b0;
      end else if (start_det) begin
         // Repeated start keeps the register address already set
         state        <= DS_RX;  // see RQ10
         bit_cnt      <= 4'h0;
         byte_idx     <= 3'h0;
         bus.s_sda_oe <= 1'b0;
      end else begin
         case (state)
            DS_RX: begin
               if (scl_rise && bit_cnt != CRP_ACK_BIT) begin
                  shreg   <= {shreg[6:0], bus.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (rx_done) begin
                  if (rx_accept) begin
                     bus.s_sda_oe <= 1'b1;  // see RQ12
                     state        <= DS_RX_ACK;
                     if (byte_idx == 3'h0) begin
                        rd_mode <= shreg[0];  // see RQ8
                     end
                  end else begin
                     // Not ours, or a byte too many: leave SDA alone
                     state <= DS_SKIP;
                  end
               end
            end
            DS_RX_ACK: begin
               if (scl_fall) begin
                  if (rd_mode) begin
                     // Value was fetched at the address ack
                     txbuf        <= rdata_in;  // see RQ13
                     shreg        <= {rdata_in[22:16], 1'b0};
                     bus.s_sda_oe <= ~rdata_in[23];  // see RQ10
                     bit_cnt      <= 4'h1;
                     byte_idx     <= 3'h0;
                     state        <= DS_TX;
                  end else begin
                     bus.s_sda_oe <= 1'b0;
                     bit_cnt      <= 4'h0;
                     byte_idx     <= byte_idx + 3'h1;
                     state        <= DS_RX;
                  end
               end
            end
            DS_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == CRP_ACK_BIT) begin
                     bus.s_sda_oe <= 1'b0;
                     state        <= DS_TX_ACK;
                  end else begin
                     bus.s_sda_oe <= ~shreg[7];  // see RQ10
                     shreg        <= {shreg[6:0], 1'b0};
                     bit_cnt      <= bit_cnt + 4'h1;
                  end
               end
            end
            DS_TX_ACK: begin
               if (scl_rise) begin
                  ack_ok <= ~bus.sda;  // see RQ11
               end else if (scl_fall) begin
                  if (ack_ok && byte_idx != CRP_TX_LAST) begin
                     // First bit goes out on this fall, or a bit is lost
                     shreg        <= {next_tx_byte[6:0], 1'b0};
                     bus.s_sda_oe <= ~next_tx_byte[7];  // see RQ10
                     bit_cnt      <= 4'h1;
                     byte_idx     <= byte_idx + 3'h1;
                     state        <= DS_TX;
                  end else begin
                     // Nack or third byte done: wait for the stop
                     state <= DS_SKIP;  // see RQ11
                  end
               end
            end
            DS_SKIP: begin
               bus.s_sda_oe <= 1'b0;
            end
            default: begin
               bus.s_sda_oe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Address and data fields, taken only from acknowledged bytes
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         space_out  <= 8'h00;
         offset_out <= 16'h0000;
         wdata_out  <= 24'h000000;
      end else if (rx_done && rx_accept) begin
         case (byte_idx)
            CRP_IDX_SPC: space_out         <= shreg;  // see RQ5
            CRP_IDX_OHI: offset_out[15:8]  <= shreg;  // see RQ5
            CRP_IDX_OLO: offset_out[7:0]   <= shreg;  // see RQ5
            CRP_IDX_DHI: wdata_out[23:16]  <= shreg;  // see RQ7
            CRP_IDX_DMI: wdata_out[15:8]   <= shreg;  // see RQ7
            CRP_IDX_DLO: wdata_out[7:0]    <= shreg;  // see RQ7
            default: begin
               space_out <= space_out;
            end
         endcase
      end
   end

   // Strobes: one write per third data byte, one fetch per read
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         wr_out <= 1'b0;
         rd_out <= 1'b0;
      end else begin
         wr_out <= rx_done & rx_accept & (byte_idx == CRP_IDX_DLO);  // see RQ13
         rd_out <= rx_done & rx_accept & (byte_idx == 3'h0)
                   & shreg[0];  // see RQ13
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         active_out <= 1'b0;
      end else begin
         active_out <= (state != DS_IDLE) & (state != DS_SKIP) & ~stop_det;
      end
   end

   // Registers have no other path in: this port only
   // (see RQ4); a second port is a second instance (see RQ1)
endmodule : crp_device

/* File: logic/crp_host.sv */
// Host end: two-wire master issuing 24-bit register writes and reads
`timescale 1ns/1ps
module crp_host
   import crp_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   crp_if.host              bus,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [7:0]  dev_addr_in,
   input  wire logic [7:0]  space_in,
   input  wire logic [15:0] offset_in,
   input  wire logic [23:0] wdata_in,
   output logic             busy_out,
   output logic             done_out,
   output logic             nack_out,
   output logic             lost_out,
   output logic [23:0]      rdata_out
);

   ////////////////////////////////////////////////////////////////////
   crp_host_st_t state;
   logic [6:0]   qcnt;
   logic         tick;
   logic [1:0]   phase;
   logic [3:0]   bit_cnt;
   logic [2:0]   byte_idx;
   logic         is_rd;
   logic         fail;
   logic [7:0]   dev;
   logic [7:0]   space;
   logic [15:0]  offset;
   logic [23:0]  wdata;
   logic [23:0]  rxbuf;
   logic [7:0]   cur;
   logic         rx_byte;
   logic         last_byte;

   // Byte order on the wire for each transfer kind
   function automatic logic [7:0] tx_byte(input logic [2:0] i);
      case (i)
         3'h0:        tx_byte = {dev[7:1], 1'b0};
         CRP_IDX_SPC: tx_byte = space;
         CRP_IDX_OHI: tx_byte = offset[15:8];
         CRP_IDX_OLO: tx_byte = offset[7:0];
         CRP_IDX_DHI: tx_byte = is_rd ? {dev[7:1], 1'b1}
                                      : crp_word_byte(wdata, 2'h0);
         CRP_IDX_DMI: tx_byte = crp_word_byte(wdata, 2'h1);
         default:     tx_byte = crp_word_byte(wdata, 2'h2);
      endcase
   endfunction : tx_byte

   assign tick      = (qcnt == CRP_QTR_LAST);
   assign cur       = tx_byte(byte_idx);
   assign rx_byte   = is_rd & (byte_idx > CRP_IDX_DHI);
   assign last_byte = is_rd ? (byte_idx == CRP_IDX_RLST)
                            : (byte_idx == CRP_IDX_DLO);

   ////////////////////////////////////////////////////////////////////
   // Quarter-bit enable; idle keeps it parked
   always_ff @(posedge clk_in) begin
      if (!resetn_in || state == HS_IDLE || tick) begin
         qcnt <= 7'h00;
      end else begin
         qcnt <= qcnt + 7'h01;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state        <= HS_IDLE;
         phase        <= 2'h0;
         bit_cnt      <= 4'h0;
         byte_idx     <= 3'h0;
         is_rd        <= 1'b0;
         fail         <= 1'b0;
         dev          <= 8'h00;
         space        <= 8'h00;
         offset       <= 16'h0000;
         wdata        <= 24'h000000;
         rxbuf        <= 24'h000000;
         busy_out     <= 1'b0;
         done_out     <= 1'b0;
         nack_out     <= 1'b0;
         lost_out     <= 1'b0;
         rdata_out    <= 24'h000000;
         bus.m_scl_o  <= 1'b0;
         bus.m_sda_o  <= 1'b0;
         bus.m_scl_oe <= 1'b0;
         bus.m_sda_oe <= 1'b0;
      end else begin
         done_out <= 1'b0;
         case (state)
            HS_IDLE: begin
               // Refused while another master holds the bus
               if ((wr_in || rd_in) && bus.scl && bus.sda) begin  // see RQ1
                  is_rd    <= rd_in & ~wr_in;  // see RQ9
                  dev      <= dev_addr_in;
                  space    <= space_in;
                  offset   <= offset_in;
                  wdata    <= wdata_in;
                  fail     <= 1'b0;
                  byte_idx <= 3'h0;
                  phase    <= 2'h0;
                  busy_out <= 1'b1;
                  nack_out <= 1'b0;
                  lost_out <= 1'b0;
                  state    <= HS_START;
               end
            end
            HS_START: if (tick) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: bus.m_sda_oe <= 1'b0;
                  2'h1: bus.m_scl_oe <= 1'b0;
                  2'h2: bus.m_sda_oe <= 1'b1;
                  default: begin
                     bus.m_scl_oe <= 1'b1;
                     bit_cnt      <= 4'h0;
                     state        <= HS_BIT;
                  end
               endcase
            end
            HS_BIT: if (tick) begin
               // A slave holding SCL low stretches the high phase
               if (phase != 2'h2 || bus.scl) begin
                  phase <= phase + 2'h1;
               end
               case (phase)
                  2'h0: begin
                     if (bit_cnt == CRP_ACK_BIT) begin
                        bus.m_sda_oe <= rx_byte & ~last_byte;  // see RQ11
                     end else begin
                        bus.m_sda_oe <= ~rx_byte & ~cur[3'(4'h7 - bit_cnt)];
                     end
                  end
                  2'h1: bus.m_scl_oe <= 1'b0;
                  2'h2: if (bus.scl) begin
                     if (bit_cnt != CRP_ACK_BIT && rx_byte) begin
                        rxbuf <= {rxbuf[22:0], bus.sda};  // see RQ10
                     end else if (bit_cnt == CRP_ACK_BIT && !rx_byte) begin
                        fail <= bus.sda;  // see RQ12
                     end else if (!bus.m_sda_oe && !bus.sda) begin
                        // Another master won: let go at once
                        bus.m_scl_oe <= 1'b0;  // see RQ1
                        lost_out     <= 1'b1;
                        done_out     <= 1'b1;
                        busy_out     <= 1'b0;
                        state        <= HS_IDLE;
                     end
                  end
                  default: begin
                     bus.m_scl_oe <= 1'b1;
                     if (bit_cnt != CRP_ACK_BIT) begin
                        bit_cnt <= bit_cnt + 4'h1;
                     end else begin
                        bit_cnt  <= 4'h0;
                        byte_idx <= byte_idx + 3'h1;
                        if (fail || last_byte) begin
                           state <= HS_STOP;  // see RQ6
                        end else if (is_rd && byte_idx == CRP_IDX_OLO) begin
                           state <= HS_START;  // see RQ10
                        end
                     end
                  end
               endcase
            end
            HS_STOP: if (tick) begin
               phase <= phase + 2'h1;
               case (phase)
                  2'h0: bus.m_sda_oe <= 1'b1;
                  2'h1: bus.m_scl_oe <= 1'b0;
                  2'h2: bus.m_sda_oe <= 1'b0;
                  default: begin
                     done_out  <= 1'b1;  // see RQ7
                     busy_out  <= 1'b0;
                     nack_out  <= fail;
                     rdata_out <= rxbuf;
                     state     <= HS_IDLE;
                  end
               endcase
            end
            default: state <= HS_IDLE;
         endcase
      end
   end
endmodule : crp_host

/* File: bench/crp_bus_chk.sv */
// Wire-level checker for the two-wire control register bus
`timescale 1ns/1ps
module crp_bus_chk (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic scl,
   input wire logic sda,
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe
);
   logic       prev_scl;
   logic       prev_sda;
   logic       is_rd;
   logic       acked;
   logic       in_xfer;
   logic [3:0] bit_cnt;
   logic [2:0] byte_cnt;
   wire        scl_rise = scl & ~prev_scl;
   wire        start_c  = scl & prev_scl & prev_sda & ~sda;
   wire        stop_c   = scl & prev_scl & ~prev_sda & sda;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in) begin
      prev_scl <= resetn_in ? scl : 1'b1;
      prev_sda <= resetn_in ? sda : 1'b1;
   end

   // Counts restart at every start, so a repeated start opens a new frame
   always_ff @(posedge clk_in) begin
      if (!resetn_in || start_c) begin
         bit_cnt  <= 4'h0;
         byte_cnt <= 3'h0;
      end else if (scl_rise && bit_cnt == 4'h8) begin
         bit_cnt  <= 4'h0;
         byte_cnt <= (byte_cnt == 3'h7) ? byte_cnt : byte_cnt + 3'h1;
      end else if (scl_rise) begin
         bit_cnt  <= bit_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         is_rd   <= 1'b0;
         acked   <= 1'b0;
         in_xfer <= 1'b0;
      end else begin
         if (start_c) in_xfer <= 1'b1;
         else if (stop_c) in_xfer <= 1'b0;
         if (start_c) acked <= 1'b0;
         else if (scl_rise && byte_cnt == 3'h0 && bit_cnt == 4'h8)
            acked <= ~sda;
         if (scl_rise && byte_cnt == 3'h0 && bit_cnt == 4'h7) is_rd <= sda;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_ack_bit;
      scl_rise && bit_cnt == 4'h8 && acked;
   endsequence
   sequence s_stop;
      stop_c && acked;
   endsequence

   property p_oe_scl_low;
      $changed(s_sda_oe) |-> !scl;
   endproperty
   property p_addr_listen;
      scl_rise && byte_cnt == 3'h0 && bit_cnt < 4'h8 |-> !s_sda_oe;
   endproperty
   property p_wr_ack;
      s_ack_bit ##0 (!is_rd && byte_cnt >= 3'h1 && byte_cnt <= 3'h6)
         |-> !sda && s_sda_oe;
   endproperty
   property p_rd_bits;
      scl_rise && is_rd && acked && byte_cnt >= 3'h1 && byte_cnt <= 3'h3
         && bit_cnt < 4'h8 |-> !m_sda_oe;
   endproperty
   property p_rd_master_ack;
      s_ack_bit ##0 (is_rd && (byte_cnt == 3'h1 || byte_cnt == 3'h2))
         |-> m_sda_oe && !s_sda_oe;
   endproperty
   property p_rd_nack_stop;
      s_ack_bit ##0 (is_rd && byte_cnt == 3'h3)
         |-> (!m_sda_oe && sda) ##[1:700] stop_c;
   endproperty
   property p_stop_count;
      s_stop |-> (is_rd ? byte_cnt == 3'h4 : byte_cnt == 3'h7);
   endproperty
   property p_sr_order;
      start_c && in_xfer && acked |-> !is_rd && byte_cnt == 3'h4;
   endproperty
   property p_stop_quiet;
      stop_c |-> !s_sda_oe [*8];
   endproperty

   a_oe_scl_low: assert property (p_oe_scl_low)
      else $error("device moved sda while scl high");
   a_addr_listen: assert property (p_addr_listen)
      else $error("device drove sda in address byte");
   a_wr_ack: assert property (p_wr_ack)
      else $error("written byte not acknowledged");
   a_rd_bits: assert property (p_rd_bits)
      else $error("host drove sda in read data");
   a_rd_master_ack: assert property (p_rd_master_ack)
      else $error("read byte ack wrong");
   a_rd_nack_stop: assert property (p_rd_nack_stop)
      else $error("last read byte not nacked and stopped");
   a_stop_count: assert property (p_stop_count)
      else $error("stop after wrong byte count");
   a_sr_order: assert property (p_sr_order)
      else $error("repeated start out of place");
   a_stop_quiet: assert property (p_stop_quiet)
      else $error("device drove sda after stop");
endmodule : crp_bus_chk

/* File: bench/tb.sv */
// Testbench: host end and device end joined by the bus
`timescale 1ns/1ps
module tb;
   import crp_pkg::*;
   logic        clk_in, resetn_in, wr_in, rd_in, addr_load_in;
   logic [7:0]  dev_addr_in, space_in, addr_val_in;
   logic [15:0] offset_in;
   logic [23:0] wdata_in, rdata_in;
   logic        busy_out, done_out, nack_out, lost_out;
   logic        wr_out, rd_out, active_out;
   logic [23:0] rdata_out, wdata_out, cap_wd;
   logic [7:0]  space_out, own_addr_out, cap_sp;
   logic [15:0] offset_out, cap_off;
   logic        cap_act;
   int          n_fail = 0;
   int          total_checks = 0;
   int          wr_cnt = 0;
   int          rd_cnt = 0;

   crp_if i_crp_if ();
   crp_host i_crp_host (.clk_in, .resetn_in, .bus(i_crp_if.host), .wr_in,
      .rd_in, .dev_addr_in, .space_in, .offset_in, .wdata_in, .busy_out,
      .done_out, .nack_out, .lost_out, .rdata_out);
   crp_device i_crp_device (.clk_in, .resetn_in, .bus(i_crp_if.dev),
      .addr_load_in, .addr_val_in, .rdata_in, .wr_out, .rd_out, .space_out,
      .offset_out, .wdata_out, .own_addr_out, .active_out);
   crp_bus_chk i_crp_bus_chk (.clk_in(clk_in), .resetn_in(resetn_in),
      .scl(i_crp_if.scl), .sda(i_crp_if.sda), .m_scl_o(i_crp_if.m_scl_o),
      .m_scl_oe(i_crp_if.m_scl_oe), .m_sda_o(i_crp_if.m_sda_o),
      .m_sda_oe(i_crp_if.m_sda_oe), .s_sda_o(i_crp_if.s_sda_o),
      .s_sda_oe(i_crp_if.s_sda_oe));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // Strobes last one cycle, so capture fields on the pulse itself
   always @(posedge clk_in) begin
      if (wr_out === 1'b1) begin
         wr_cnt  <= wr_cnt + 1;
         cap_wd  <= wdata_out;
      end
      if ((wr_out | rd_out) === 1'b1) begin
         cap_sp  <= space_out;
         cap_off <= offset_out;
         cap_act <= active_out;
      end
      if (rd_out === 1'b1) rd_cnt <= rd_cnt + 1;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic conclude;
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // One host request; a full frame takes about 18k cycles
   task automatic access(input logic rd, input logic [7:0] dev,
                         input logic [7:0] sp, input logic [15:0] off,
                         input logic [23:0] d, input logic ok);
      int n;
      int w0;
      int r0;
      n  = 0;
      w0 = wr_cnt;
      r0 = rd_cnt;
      @(posedge clk_in);
      wr_in       <= ~rd;
      rd_in       <= rd;
      dev_addr_in <= dev;
      space_in    <= sp;
      offset_in   <= off;
      wdata_in    <= d;
      rdata_in    <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      @(negedge clk_in);
      chk(24'(busy_out), 24'h1);
      do begin
         @(negedge clk_in);
         n++;
      end while (done_out !== 1'b1 && n < 40000);
      chk(24'(done_out), 24'h1);
      chk(24'(nack_out), 24'(!ok));
      chk(24'(lost_out), 24'h0);
      chk(24'(active_out), 24'h0);
      chk(24'(wr_cnt - w0), 24'(ok && !rd));
      chk(24'(rd_cnt - r0), 24'(ok && rd));
      if (ok) begin
         chk(24'(cap_act), 24'h1);
         chk(24'(cap_sp), 24'(sp));
         chk(24'(cap_off), 24'(off));
         chk(rd ? rdata_out : cap_wd, d);
      end
   endtask : access

   ////////////////////////////////////////////////////////////////////////
   initial begin
      resetn_in    = 1'b0;
      wr_in        = 1'b0;
      rd_in        = 1'b0;
      addr_load_in = 1'b0;
      addr_val_in  = 8'h00;
      dev_addr_in  = 8'h00;
      space_in     = 8'h00;
      offset_in    = 16'h0000;
      wdata_in     = 24'h000000;
      rdata_in     = 24'h000000;
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(negedge clk_in);
      chk(24'(own_addr_out), 24'hb2);
      chk(24'(busy_out), 24'h0);
      access(1'b0, 8'hb2, 8'h5a, 16'hc3a5, 24'h8142e7, 1'b1);
      access(1'b1, 8'hb2, 8'h5a, 16'hc3a5, 24'h3c990f, 1'b1);
      access(1'b0, 8'h90, 8'h11, 16'h2233, 24'h445566, 1'b0);
      @(posedge clk_in);
      addr_load_in <= 1'b1;
      addr_val_in  <= 8'h3c;
      @(posedge clk_in);
      addr_load_in <= 1'b0;
      @(negedge clk_in);
      chk(24'(own_addr_out), 24'h3c);
      access(1'b0, 8'h3c, 8'hff, 16'hffff, 24'hffffff, 1'b1);
      access(1'b1, 8'hb2, 8'h01, 16'h0002, 24'h000003, 1'b0);
      access(1'b1, 8'h3c, 8'h00, 16'h0000, 24'h80_00_01, 1'b1);
      conclude();
   end

   // Six frames need about 75k cycles; hang cut at 95k
   initial begin
      repeat (95000) @(posedge clk_in);
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      conclude();
   end
endmodule : tb
